// file: inc/dsl_cfg.svh
// Constants of the serial load port: widths, depths, reset values and timing.
`ifndef DSL_CFG_SVH
`define DSL_CFG_SVH

// ----------------------------------------------------------------------------
// Frame and storage
// ----------------------------------------------------------------------------
`define DSL_WORD_W      24
`define DSL_CNT_W       6
`define DSL_CNT_MAX     6'h3F
`define DSL_FIFO_DEPTH  8

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define DSL_DAC_RST     24'h000000
`define DSL_PIN_SYNC_RST 2'h3
// The serial clock idles high between frames, so the detector starts there.
`define DSL_PIN_SCLK_RST 2'h3

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define DSL_MCLK_MHZ     10
`define DSL_SCLK_MAX_MHZ 50

`endif

// file: inc/dsl_pkg.sv
// Types shared by the serial load port modules.
`default_nettype none
`include "dsl_cfg.svh"
package dsl_pkg;

  // --------------------------------------------------------------------------
  // Load control state
  // --------------------------------------------------------------------------
  typedef enum logic [0:0] {
    LD_FOLLOW,
    LD_WAIT
  } dsl_ld_type;

  // --------------------------------------------------------------------------
  // State of the top module outside its word FIFO
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [1:0]                sclk_s;
    logic [1:0]                sync_s;
    logic [1:0]                sdi_s;
    logic [1:0]                ldn_s;
    logic                      sclk_p;
    logic                      sync_p;
    logic                      ldn_p;
    logic [`DSL_WORD_W-1:0]    shift;
    logic [`DSL_CNT_W-1:0]     cnt;
    logic                      sout;
    logic                      push;
    logic [`DSL_WORD_W-1:0]    push_data;
    logic [`DSL_WORD_W-1:0]    inreg;
    logic [`DSL_WORD_W-1:0]    dac;
    dsl_ld_type                ld;
    logic                      clamp;
    logic                      bufpd;
    logic                      ovr;
  } dsl_state_type;

endpackage
`default_nettype wire

// file: rtl/dsl_fifo.sv
// Word FIFO between the serial receiver and the input register.
`timescale 1ns/1ps
`default_nettype none
`include "dsl_cfg.svh"
module dsl_fifo #(
  parameter int WIDTH = `DSL_WORD_W,
  parameter int DEPTH = `DSL_FIFO_DEPTH
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output var  logic             in_ready,
  output var  logic             out_valid,
  output var  logic [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [AW:0]                 cnt;
  } dsl_fifo_state_type;

  dsl_fifo_state_type q;
  dsl_fifo_state_type d;
  logic               push;
  logic               pop;

  // Pointers wrap at DEPTH so that depths other than powers of two work.
  function automatic logic [AW-1:0] ptr_next(input logic [AW-1:0] p);
    if (p == AW'(DEPTH - 1)) begin
      return '0;
    end
    return p + AW'(1);
  endfunction

  assign in_ready  = (q.cnt != (AW + 1)'(DEPTH));
  assign out_valid = (q.cnt != '0);
  assign out_data  = q.mem[q.rd];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wr] = in_data;
      d.wr        = ptr_next(q.wr);
    end
    if (pop) begin
      d.rd = ptr_next(q.rd);
    end
    unique case ({push, pop})
      2'b10: d.cnt = q.cnt + (AW + 1)'(1);
      2'b01: d.cnt = q.cnt - (AW + 1)'(1);
      2'b00,
      2'b11: d.cnt = q.cnt;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  fifo_bound_a: assert property (@(posedge clk) disable iff (!rst_n)
    q.cnt <= (AW + 1)'(DEPTH))
    else $error("FIFO count above depth");

  fifo_order_a: assert property (@(posedge clk) disable iff (!rst_n)
    (push && !pop && q.cnt == '0) |=> (out_valid && out_data == $past(in_data)))
    else $error("FIFO did not present the first word");

endmodule
`default_nettype wire

// file: rtl/dsl_load_port.sv
// Serial host port and output-load control of a single-channel DAC.
//
// Contract
// R1: While frame select is low, sample serial_in on each serial clock fall.
// R2: Act on the shifted word only when frame select rises; that latches it.
// R3: Controller keeps serial_in stable at the sampling falling clock edge.
// R4: Shift serial_out on rising clock edges; controller captures on falls.
// R5: Controller runs the serial clock no faster than 50 MHz.
// R6: Load held low: every input register write also updates the DAC.
// R7: Load high at write: DAC holds, then updates on next load falling edge.
// R8: Reset low returns power-on state: output clamped, buffer powered down.
// R9: Words travel MSB first; a frame has a fixed word length.
`timescale 1ns/1ps
`default_nettype none
`include "dsl_cfg.svh"
module dsl_load_port
  import dsl_pkg::*;
#(
  parameter int FIFO_DEPTH = `DSL_FIFO_DEPTH
) (
  input  wire logic                   I_MCLK,
  input  wire logic                   I_RST_N,
  input  wire logic                   I_SCLK,
  input  wire logic                   I_SYNC_N,
  input  wire logic                   I_SERIAL_IN,
  input  wire logic                   I_OUTPUT_LOAD_N,
  output var  logic                   O_SERIAL_OUT,
  output var  logic [`DSL_WORD_W-1:0] O_DAC_CODE,
  output var  logic [`DSL_WORD_W-1:0] O_INPUT_REG,
  output var  logic                   O_OUT_CLAMP,
  output var  logic                   O_BUF_PD,
  output var  logic                   O_OVERRUN
);

  // --------------------------------------------------------------------------
  // Constants and state
  // --------------------------------------------------------------------------
  localparam int W = `DSL_WORD_W;

  // The serial clock is sampled, so it must stay well below the sampling
  // clock; the pin limit of the controller is far above what we can follow.

  localparam dsl_state_type ST_RST = '{
    sclk_s:    `DSL_PIN_SCLK_RST,
    sync_s:    `DSL_PIN_SYNC_RST,
    sdi_s:     2'h0,
    ldn_s:     `DSL_PIN_SYNC_RST,
    sclk_p:    1'b1,
    sync_p:    1'b1,
    ldn_p:     1'b1,
    shift:     `DSL_DAC_RST,
    cnt:       '0,
    sout:      1'b0,
    push:      1'b0,
    push_data: `DSL_DAC_RST,
    inreg:     `DSL_DAC_RST,
    dac:       `DSL_DAC_RST,
    ld:        LD_FOLLOW,
    clamp:     1'b1,
    bufpd:     1'b1,
    ovr:       1'b0
  };

  dsl_state_type         st_q;
  dsl_state_type         st_d;
  logic                  sclk_rise;
  logic                  sclk_fall;
  logic                  sync_rise;
  logic                  sync_fall;
  logic                  ldn_fall;
  logic                  frame_on;
  logic                  fifo_in_ready;
  logic                  fifo_out_valid;
  logic [W-1:0]          fifo_out_data;
  logic                  drain_ready;
  logic                  pop;
  logic                  dac_load;

  // --------------------------------------------------------------------------
  // Edge decoding on synchronised pins
  // --------------------------------------------------------------------------
  function automatic logic rise_f(input logic prev, input logic cur);
    return !prev && cur;
  endfunction

  function automatic logic fall_f(input logic prev, input logic cur);
    return prev && !cur;
  endfunction

  assign sclk_rise = rise_f(st_q.sclk_p, st_q.sclk_s[1]);
  assign sclk_fall = fall_f(st_q.sclk_p, st_q.sclk_s[1]);
  assign sync_rise = rise_f(st_q.sync_p, st_q.sync_s[1]);
  assign sync_fall = fall_f(st_q.sync_p, st_q.sync_s[1]);
  assign ldn_fall  = fall_f(st_q.ldn_p, st_q.ldn_s[1]);
  assign frame_on  = !st_q.sync_s[1];

  // --------------------------------------------------------------------------
  // Received words queue
  // --------------------------------------------------------------------------
  dsl_fifo #(
    .WIDTH (W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (I_MCLK),
    .rst_n     (I_RST_N),
    .in_valid  (st_q.push),
    .in_data   (st_q.push_data),
    .in_ready  (fifo_in_ready),
    .out_valid (fifo_out_valid),
    .out_data  (fifo_out_data),
    .out_ready (drain_ready)
  );

  // A word held back by a high load input stalls the queue, so later words
  // cannot overwrite the input register before the DAC has taken it.
  always_comb begin
    unique case (st_q.ld)
      LD_FOLLOW: drain_ready = 1'b1;
      LD_WAIT:   drain_ready = 1'b0;
    endcase
  end

  assign pop      = fifo_out_valid && drain_ready;
  assign dac_load = ldn_fall || (pop && !st_q.ldn_s[1]);

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    st_d        = st_q;
    st_d.ovr    = 1'b0;
    st_d.sclk_s = {st_q.sclk_s[0], I_SCLK};
    st_d.sync_s = {st_q.sync_s[0], I_SYNC_N};
    st_d.sdi_s  = {st_q.sdi_s[0], I_SERIAL_IN};
    st_d.ldn_s  = {st_q.ldn_s[0], I_OUTPUT_LOAD_N};
    st_d.sclk_p = st_q.sclk_s[1];
    st_d.sync_p = st_q.sync_s[1];
    st_d.ldn_p  = st_q.ldn_s[1];

    // A new frame restarts the bit count and presents the old MSB.
    if (sync_fall) begin
      st_d.cnt  = '0;
      st_d.sout = st_q.shift[W-1];                                 // R4
    end
    if (frame_on && sclk_fall) begin
      st_d.shift = {st_q.shift[W-2:0], st_q.sdi_s[1]};             // R1 R9
      if (st_q.cnt != `DSL_CNT_MAX) begin
        st_d.cnt = st_q.cnt + `DSL_CNT_W'(1);
      end
    end
    if (frame_on && sclk_rise) begin
      st_d.sout = st_q.shift[W-1];                                 // R4 R9
    end

    // Hand the frame to the queue; a short or long frame is dropped.
    if (st_q.push && fifo_in_ready) begin
      st_d.push = 1'b0;
    end
    if (sync_rise && st_q.cnt == `DSL_CNT_W'(W)) begin             // R2 R9
      if (st_d.push) begin
        st_d.ovr = 1'b1;
      end else begin
        st_d.push      = 1'b1;
        st_d.push_data = st_q.shift;                               // R2
      end
    end

    // Output load control.
    if (ldn_fall) begin
      st_d.dac   = st_q.inreg;                                     // R7
      st_d.ld    = LD_FOLLOW;
      st_d.clamp = 1'b0;
      st_d.bufpd = 1'b0;
    end
    if (pop) begin
      st_d.inreg = fifo_out_data;
      if (st_q.ldn_s[1]) begin
        st_d.ld = LD_WAIT;                                         // R7
      end else begin
        st_d.dac   = fifo_out_data;                                // R6
        st_d.clamp = 1'b0;
        st_d.bufpd = 1'b0;
      end
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      st_q <= ST_RST;                                              // R8
    end else begin
      st_q <= st_d;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign O_SERIAL_OUT = st_q.sout;
  assign O_DAC_CODE   = st_q.dac;
  assign O_INPUT_REG  = st_q.inreg;
  assign O_OUT_CLAMP  = st_q.clamp;
  assign O_BUF_PD     = st_q.bufpd;
  assign O_OVERRUN    = st_q.ovr;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  shift_in_a: assert property ( // R1
    @(posedge I_MCLK) disable iff (!I_RST_N)
    (frame_on && sclk_fall)
      |=> (st_q.shift[0] == $past(st_q.sdi_s[1])
           && st_q.shift[W-1:1] == $past(st_q.shift[W-2:0])))
    else $error("Serial input not shifted in at clock fall");

  shift_idle_a: assert property ( // R1
    @(posedge I_MCLK) disable iff (!I_RST_N)
    !frame_on |=> $stable(st_q.shift))
    else $error("Shift register moved outside a frame");

  word_latch_a: assert property ( // R2
    @(posedge I_MCLK) disable iff (!I_RST_N)
    (sync_rise && st_q.cnt == `DSL_CNT_W'(W) && !st_q.push)
      |=> (st_q.push && st_q.push_data == $past(st_q.shift)))
    else $error("Complete frame not latched at frame end");

  push_cause_a: assert property ( // R2
    @(posedge I_MCLK) disable iff (!I_RST_N)
    $rose(st_q.push) |-> $past(sync_rise))
    else $error("Word latched without frame end");

  out_shift_a: assert property ( // R4
    @(posedge I_MCLK) disable iff (!I_RST_N)
    (frame_on && sclk_rise) |=> O_SERIAL_OUT == $past(st_q.shift[W-1]))
    else $error("Serial output not updated at clock rise");

  out_hold_a: assert property ( // R4
    @(posedge I_MCLK) disable iff (!I_RST_N)
    (!sclk_rise && !sync_fall) |=> $stable(O_SERIAL_OUT))
    else $error("Serial output changed without a rising edge");

  load_follow_a: assert property ( // R6
    @(posedge I_MCLK) disable iff (!I_RST_N)
    (pop && !st_q.ldn_s[1])
      |=> (O_DAC_CODE == $past(fifo_out_data) && !O_OUT_CLAMP))
    else $error("DAC did not follow input write with load low");

  load_hold_a: assert property ( // R7
    @(posedge I_MCLK) disable iff (!I_RST_N)
    (pop && st_q.ldn_s[1])
      |=> ($stable(O_DAC_CODE) && st_q.ld == LD_WAIT)
          ##1 (st_q.ld == LD_WAIT || $past(ldn_fall)))
    else $error("DAC changed while load was high");

  load_fall_a: assert property ( // R7
    @(posedge I_MCLK) disable iff (!I_RST_N)
    (ldn_fall && !pop) |=> (O_DAC_CODE == $past(st_q.inreg)
                            && st_q.ld == LD_FOLLOW))
    else $error("Load falling edge did not transfer");

  clamp_end_a: assert property ( // R8
    @(posedge I_MCLK) disable iff (!I_RST_N)
    $fell(O_OUT_CLAMP) |-> ($past(dac_load) && !O_BUF_PD))
    else $error("Output clamp released without a DAC update");

  // The checks below pin down what may change and when, so that a stray
  // write path shows up even where no scenario compares the value.
  dac_hold_a: assert property ( // R7
    @(posedge I_MCLK) disable iff (!I_RST_N)
    !dac_load |=> $stable(O_DAC_CODE))
    else $error("DAC register changed without a load");

  inreg_hold_a: assert property ( // R6
    @(posedge I_MCLK) disable iff (!I_RST_N)
    !pop |=> $stable(O_INPUT_REG))
    else $error("Input register changed without a queued word");

  ovr_pulse_a: assert property ( // R2
    @(posedge I_MCLK) disable iff (!I_RST_N)
    O_OVERRUN |=> !O_OVERRUN)
    else $error("Overrun flag longer than one cycle");

  short_drop_a: assert property ( // R9
    @(posedge I_MCLK) disable iff (!I_RST_N)
    (sync_rise && st_q.cnt != `DSL_CNT_W'(W)) |=> !$rose(st_q.push))
    else $error("Frame of wrong length was latched");

  frame_out_a: assert property ( // R4
    @(posedge I_MCLK) disable iff (!I_RST_N)
    sync_fall |=> O_SERIAL_OUT == $past(st_q.shift[W-1]))
    else $error("Frame start did not present the old MSB");

  clamp_pair_a: assert property ( // R8
    @(posedge I_MCLK) disable iff (!I_RST_N)
    O_OUT_CLAMP == O_BUF_PD)
    else $error("Clamp and buffer power-down disagree");

  clamp_rst_a: assert property ( // R8
    @(posedge I_MCLK) disable iff (!I_RST_N)
    !$rose(O_OUT_CLAMP))
    else $error("Output clamped again outside reset");

endmodule
`default_nettype wire

// file: test/dsl_host_model.sv
// Host serial controller model that drives frames into the load port.
`timescale 1ns/1ps
`default_nettype none
module dsl_host_model (
  input  wire logic i_mclk,
  input  wire logic i_sdo,
  output var  logic o_sclk,
  output var  logic o_sync_n,
  output var  logic o_sdi
);
  // --------------------------------------------------------------------------
  // Idle levels
  // --------------------------------------------------------------------------
  // The serial clock idles high and stands still between frames, so the first
  // falling edge of a frame captures the bit shown at frame start.
  initial begin
    o_sclk   = 1'b1;
    o_sync_n = 1'b1;
    o_sdi    = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(negedge i_mclk);
  endtask

  // --------------------------------------------------------------------------
  // Frame transfer
  // --------------------------------------------------------------------------
  // Shifts n bits of w and leaves select low, so the caller can look inside.
  task automatic frame(input logic [31:0] w, input int n,
                       output logic [31:0] rb);
    rb       = 32'h00000000;
    o_sync_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      o_sdi = w[i];
      wait_clk(4);
      o_sclk = 1'b0;
      rb     = {rb[30:0], i_sdo};
      wait_clk(4);
      o_sclk = 1'b1;
    end
    wait_clk(4);
  endtask

  // A released data line shows the inverse of its last bit, never a copy.
  task automatic close();
    o_sync_n = 1'b1;
    o_sdi    = ~o_sdi;
    wait_clk(6);
  endtask
endmodule
`default_nettype wire

// file: test/tb.sv
// Self-checking bench of the serial load port with a host model.
`timescale 1ns/1ps
`default_nettype none
`include "dsl_cfg.svh"
module tb;
  logic                   mclk;
  logic                   rst_n;
  logic                   load_n;
  wire logic              sclk;
  wire logic              sync_n;
  wire logic              serial_in;
  logic                   serial_out;
  logic [`DSL_WORD_W-1:0] dac;
  logic [`DSL_WORD_W-1:0] inreg;
  logic                   clamp;
  logic                   bufpd;
  logic                   ovr;
  int                     miscompares;
  int                     cmp_count;
  int                     ovr_cnt = 0;
  logic [31:0]            rnd;
  logic [31:0]            q [11];
  logic [23:0]            exp_shift;
  logic [23:0]            exp_in;
  logic [23:0]            exp_dac;
  logic [23:0]            last_dac = 24'h000000;
  logic [23:0]            word;
  logic [23:0]            dac_log [$];

  dsl_load_port uut (
    .I_MCLK(mclk), .I_RST_N(rst_n), .I_SCLK(sclk), .I_SYNC_N(sync_n),
    .I_SERIAL_IN(serial_in), .I_OUTPUT_LOAD_N(load_n), .O_SERIAL_OUT(serial_out),
    .O_DAC_CODE(dac), .O_INPUT_REG(inreg), .O_OUT_CLAMP(clamp),
    .O_BUF_PD(bufpd), .O_OVERRUN(ovr)
  );
  dsl_host_model host (
    .i_mclk(mclk), .i_sdo(serial_out), .o_sclk(sclk), .o_sync_n(sync_n),
    .o_sdi(serial_in)
  );

  // --------------------------------------------------------------------------
  // Clock, monitors and helpers
  // --------------------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  always @(negedge mclk) begin
    if (ovr === 1'b1) ovr_cnt++;
    if (dac !== last_dac) begin
      dac_log.push_back(dac);
      last_dac = dac;
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Shift chain content after n bits of w went in, most significant first.
  function automatic logic [23:0] shift_exp(input logic [23:0] s,
                                            input logic [31:0] w,
                                            input int          n);
    for (int i = n - 1; i >= 0; i--) s = {s[22:0], w[i]};
    return s;
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic chk(input logic [23:0] got, input logic [23:0] exp,
                     input string what);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic xfer(input logic [31:0] w, input int n);
    logic [31:0] rb;
    host.frame(w, n, rb);
    cyc(4);
    chk(inreg, exp_in, "input register while select low");
    host.close();
    if (n == 24) chk(rb[23:0], exp_shift, "readback word");
    exp_shift = shift_exp(exp_shift, w, n);
    cyc(6);
  endtask

  task automatic reset_check();
    chk(dac, 24'h000000, "dac code in reset");
    chk(inreg, 24'h000000, "input register in reset");
    chk(24'(clamp), 24'h000001, "clamp in reset");
    chk(24'(bufpd), 24'h000001, "buffer power-down in reset");
    chk(24'(serial_out), 24'h000000, "serial out in reset");
  endtask

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    $display("Error at %0t: watchdog expired", $time);
    end_sim();
  end

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial begin
    {miscompares, cmp_count} = '0;
    rst_n     = 1'b0;
    load_n    = 1'b1;
    rnd       = 32'h8A0627F8;
    exp_shift = 24'h000000;
    exp_in    = 24'h000000;
    cyc(4);
    reset_check();
    cyc(2);
    rst_n = 1'b1;
    cyc(4);
    $display("Test reset done");
    // Load held low: every write reaches the DAC; corner words come first.
    load_n = 1'b0;
    for (int k = 0; k < 8; k++) begin
      rnd    = lfsr(rnd);
      word   = (k == 0) ? 24'hFFFFFF : (k == 1) ? 24'h800001 : rnd[23:0];
      xfer({8'h00, word}, 24);
      exp_in = word;
      chk(inreg, exp_in, "input register after frame");
      chk(dac, exp_in, "dac follows write");
    end
    chk(24'(clamp), 24'h000000, "clamp after update");
    chk(24'(bufpd), 24'h000000, "power-down after update");
    $display("Test follow done");
    // Load high at write: DAC holds until the next load falling edge.
    exp_dac = exp_in;
    load_n  = 1'b1;
    cyc(4);
    rnd    = lfsr(rnd);
    xfer(rnd, 24);
    exp_in = rnd[23:0];
    chk(inreg, exp_in, "input register with load high");
    chk(dac, exp_dac, "dac held with load high");
    load_n = 1'b0;
    cyc(6);
    chk(dac, exp_in, "dac after load fall");
    $display("Test held load done");
    // Frames of the wrong length are dropped, the shift chain still moves.
    foreach (q[k]) begin
      if (k < 3) begin
        rnd = lfsr(rnd);
        xfer(rnd, (k == 0) ? 23 : (k == 1) ? 25 : 1);
        chk(inreg, exp_in, "input register after bad length");
      end
    end
    chk(24'(ovr_cnt), 24'h000000, "no overrun in normal traffic");
    $display("Test bad length done");
    // Fill the queue behind a held word until frames are refused.
    exp_dac = exp_in;
    load_n  = 1'b1;
    cyc(4);
    foreach (q[k]) begin
      rnd  = lfsr(rnd);
      q[k] = rnd;
      xfer(rnd, 24);
      if (k == 0) exp_in = rnd[23:0];
    end
    chk(inreg, exp_in, "held word stays");
    chk(dac, exp_dac, "dac stays while held");
    chk(24'(ovr_cnt != 0), 24'h000001, "overrun on full queue");
    dac_log.delete();
    load_n = 1'b0;
    cyc(60);
    for (int k = 0; k < 9; k++) begin
      chk((k < dac_log.size()) ? dac_log[k] : 24'hXXXXXX, q[k][23:0],
          "drained word order");
    end
    $display("Test queue done");
    // A second reset in mid-run, then one frame to show recovery.
    load_n = 1'b1;
    cyc(4);
    rst_n = 1'b0;
    cyc(3);
    reset_check();
    rst_n     = 1'b1;
    exp_shift = 24'h000000;
    cyc(4);
    load_n = 1'b0;
    rnd    = lfsr(rnd);
    exp_in = 24'h000000;
    xfer(rnd, 24);
    exp_in = rnd[23:0];
    chk(inreg, exp_in, "input register after second reset");
    chk(dac, exp_in, "dac after second reset");
    $display("Test second reset done");
    end_sim();
  end
endmodule
`default_nettype wire
